// >>> bench/svp_chk.sv
// checker: port-level properties of the servo parameter bank
`timescale 1ns/100ps
`default_nettype none
module svp_chk
  import svp_pkg::*;
(
  input wire logic                              CLOCK_I,
  input wire logic                              RST_I,
  input wire logic                              CE_I,
  input wire logic        [7:0]                 ADDR_I,
  input wire logic        [7:0]                 WDATA_I,
  input wire logic                              WR_I,
  input wire logic                              RD_I,
  input wire logic        [7:0]                 RDATA_O,
  input wire logic                              IRQ_O,
  input wire logic        [7:0]                 TEMP_RAW_I,
  input wire logic        [7:0]                 SUPPLY_RAW_I,
  input wire logic        [7:0]                 DEST_ADDR_I,
  input wire logic                              ADDR_HIT_O,
  input wire logic        [svp_pkg::POS_W-1:0]  GOAL_POS_I,
  input wire logic                              GOAL_STB_I,
  input wire logic        [svp_pkg::POS_W-1:0]  CMD_POS_O,
  input wire logic        [svp_pkg::POS_W-1:0]  CUR_POS_I,
  input wire logic signed [svp_pkg::DRIVE_W-1:0] DRIVE_O,
  input wire logic                              REACHED_O,
  input wire logic                              RAMP_ACTIVE_O
);
  logic [7:0]  sh [NUM_BYTES];
  logic [3:0]  msk_q;
  logic [15:0] ceil, lo, hi, g;
  logic [10:0] err;
  logic [7:0]  rdx;
  logic        rsv, hit;
  // shadow store; refused node and ramp ratio writes skipped, reserved bytes masked on read so read compares stay honest
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      for (int i = 0; i < NUM_BYTES; i++) sh[i] <= DEFAULT_IMAGE[i];
      msk_q <= MASK_RESET;
    end else if (CE_I && WR_I) begin
      if (ADDR_I < NUM_BYTES && !(ADDR_I == OFF_NODE && WDATA_I >= BROADCAST_ADDR)
          && !(ADDR_I == OFF_RAMP_RATIO && WDATA_I > RAMP_RATIO_MAX)) sh[ADDR_I] <= WDATA_I;
      if (ADDR_I == OFF_MASK) msk_q <= WDATA_I[3:0];
    end
  end
  // expected clamp, error magnitude, read data and address match
  always_comb begin
    ceil = {sh[17], sh[16]};
    lo = {sh[21], sh[20]};
    hi = {sh[23], sh[22]};
    g = (16'(GOAL_POS_I) > hi) ? hi : 16'(GOAL_POS_I);
    g = (g < lo) ? lo : g;
    err = (CUR_POS_I > CMD_POS_O) ? 11'(CUR_POS_I - CMD_POS_O) : 11'(CMD_POS_O - CUR_POS_I);
    rsv = ADDR_I == OFF_RSVD4 || (ADDR_I >= OFF_RSVD34 && ADDR_I < OFF_FLASH);
    rdx = (ADDR_I < NUM_BYTES && !rsv) ? sh[ADDR_I] : 8'h00;
    hit = DEST_ADDR_I == BROADCAST_ADDR || DEST_ADDR_I == sh[0];
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I || !CE_I);
  AST_CEIL: assert property (1'b1 |=> $past(ceil) >= 16'(DRIVE_O[15] ? -DRIVE_O : DRIVE_O))
    else $error("drive above ceiling");
  AST_SETTLE: assert property (err < 11'(sh[10]) |=> DRIVE_O == 16'sh0000 && REACHED_O)
    else $error("drive not zero inside settle band");
  AST_ZERO: assert property (CUR_POS_I == CMD_POS_O |=> DRIVE_O == 16'sh0000 && REACHED_O)
    else $error("drive not zero at target");
  AST_CLAMP: assert property (GOAL_STB_I |=> 16'(CMD_POS_O) == $past(g))
    else $error("goal not confined to travel window");
  AST_RD_IDLE: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data outside its cycle");
  AST_RD: assert property (RD_I && ADDR_I < 8'h27 |=> RDATA_O == $past(rdx))
    else $error("read data differs from store");
  AST_HIT: assert property (1'b1 |=> ADDR_HIT_O == $past(hit))
    else $error("address match wrong");
  AST_TEMP: assert property (TEMP_RAW_I > sh[5] && msk_q[ST_TEMP] |=> IRQ_O)
    else $error("temperature fault missed");
  AST_SUPLO: assert property (SUPPLY_RAW_I < sh[6] && msk_q[ST_SUP_LO] |=> IRQ_O)
    else $error("low supply fault missed");
  AST_SUPHI: assert property (SUPPLY_RAW_I > sh[7] && msk_q[ST_SUP_HI] |=> IRQ_O)
    else $error("high supply fault missed");
  AST_RAMP: assert property (GOAL_STB_I && sh[9] != 8'h00 |=> RAMP_ACTIVE_O)
    else $error("ramp did not start");
endmodule : svp_chk
`default_nettype wire

// >>> bench/svp_ctl.sv
// controller model: register reads and writes on the plain byte port
`timescale 1ns/100ps
`default_nettype none
module svp_ctl (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // idle bus from time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one write; the idle cycle after it keeps one assignment per strobe per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  // two-byte value, low byte first
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask : wr16
  // one read; data taken in the one cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
    @(posedge clk_i);
  endtask : rd
endmodule : svp_ctl
`default_nettype wire

// >>> bench/svp_param_bank_tb_top.sv
// testbench: store image, refusals, drive shaping, faults, ramp and indicator
`timescale 1ns/100ps
`default_nettype none
module svp_param_bank_tb_top;
  import svp_pkg::*;
  localparam int unsigned TC = 8;
  logic clk, rst, ce, wr, rd, stb, hit, rch, ramp, led, irq;
  logic [7:0] addr, wd, rdat, temp, sup, dest, d, a, v;
  logic [POS_W-1:0] goal, cmd, cur;
  logic signed [DRIVE_W-1:0] raw, drv;
  logic [7:0] img [NUM_BYTES];
  logic [15:0] cor [6] = '{16'h00FE, 16'h00FD, 16'h0833, 16'h0832, 16'h0455, 16'h22AA};
  int es [6] = '{0, 3, 5, 5, 5, 300};
  int rs [6] = '{2000, 2000, 2000, -3, 50, -2000};
  int n_errors, comparisons, seed, k, n, e, r;

  svp_param_bank #(.TICK_CYC(TC)) u_dut (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr),
    .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .IRQ_O(irq), .TEMP_RAW_I(temp),
    .SUPPLY_RAW_I(sup), .DEST_ADDR_I(dest), .ADDR_HIT_O(hit), .GOAL_POS_I(goal), .GOAL_STB_I(stb),
    .CMD_POS_O(cmd), .CUR_POS_I(cur), .RAW_DRIVE_I(raw), .DRIVE_O(drv), .REACHED_O(rch),
    .RAMP_ACTIVE_O(ramp), .FAULT_LED_O(led));
  svp_ctl u_ctl (.clk_i(clk), .rdata_i(rdat), .addr_o(addr), .wdata_o(wd), .wr_o(wr), .rd_o(rd));

  // which writes the store keeps
  function automatic bit kept(input logic [7:0] x, input logic [7:0] y);
    return !(x == OFF_RSVD4 || (x >= OFF_RSVD34 && x < OFF_FLASH) || x > OFF_FLASH
             || (x == OFF_NODE && y >= BROADCAST_ADDR) || (x == OFF_RAMP_RATIO && y > RAMP_RATIO_MAX));
  endfunction : kept
  // shaped drive: settle band first, then floor, then ceiling
  function automatic logic [15:0] shape(input int ee, input int rr, input int sb, input int fl, input int cl);
    int m;
    m = rr < 0 ? -rr : rr;
    if (ee < 0) ee = -ee;
    if (ee == 0 || ee < sb) return 16'h0000;
    if (m != 0 && m < fl) m = fl;
    if (m > cl) m = cl;
    return 16'(rr < 0 ? -m : m);
  endfunction : shape
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // whole store against the default image, reserved bytes read as zero
  task automatic img_chk();
    for (int i = 0; i < NUM_BYTES; i++) begin
      img[i] = kept(8'(i), 8'h00) ? DEFAULT_IMAGE[i] : 8'h00;
      u_ctl.rd(8'(i), d);
      chk(16'(d), 16'(img[i]));
    end
    u_ctl.rd(8'h30, d);
    chk(16'(d), 16'h0000);
  endtask : img_chk

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst, ce, stb, goal, cur, raw, temp, sup, dest} = {1'b1, 1'b1, 1'b0, 10'h1F4, 10'h1F4, 16'h0, 8'h0, 8'h70, 8'h0};
    {seed, n_errors, comparisons} = {32'd61, 32'd0, 32'd0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    img_chk();
    // corner then random writes, each read back
    for (k = 0; k < 50; k++) begin
      {a, v} = k < 6 ? cor[k] : 16'($random(seed));
      if (k >= 6) a = 8'($unsigned($random(seed)) % NUM_BYTES);
      u_ctl.wr(a, v);
      if (kept(a, v)) img[a] = v;
      u_ctl.rd(a, d);
      chk(16'(d), 16'(img[a]));
    end
    // reboot in mid-run restores the defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    img_chk();
    for (k = 0; k < 3; k++) begin
      dest <= k == 0 ? BROADCAST_ADDR : k == 1 ? 8'hFD : 8'($random(seed)) & 8'h7F;
      @(posedge clk);
      @(negedge clk);
      chk(16'(hit), 16'(k < 2));
      @(posedge clk);
    end
    u_ctl.wr16(OFF_CEIL, 16'h0100);
    u_ctl.wr(OFF_SETTLE, 8'h05);
    u_ctl.wr(OFF_FLOOR, 8'h20);
    for (k = 0; k < 3; k++) begin
      goal <= k == 0 ? 10'h3FF : k == 1 ? 10'h000 : 10'h1F4;
      stb <= 1'b1;
      @(posedge clk);
      stb <= 1'b0;
      @(negedge clk);
      chk(16'(cmd), k == 0 ? 16'h03EA : k == 1 ? 16'h0015 : 16'h01F4);
      @(posedge clk);
    end
    // table of error and loop drive, then random pairs
    for (k = 0; k < 16; k++) begin
      e = k < 6 ? es[k] : $random(seed) % 40;
      r = k < 6 ? rs[k] : $random(seed) % 3000;
      cur <= 10'(500 + e);
      raw <= 16'(r);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(drv, shape(e, r, 5, 32, 256));
      chk(16'(rch), 16'(e > -5 && e < 5));
      @(posedge clk);
    end
    // enable low must freeze the shaped drive while error and loop drive move
    ce <= 1'b0;
    cur <= 10'd700;
    raw <= 16'sh0021;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(drv, shape(e, r, 5, 32, 256));
    @(posedge clk);
    ce <= 1'b1;
    // keep away from the goal so the reached event stays quiet
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(drv, 16'h0021);
    u_ctl.wr(OFF_MASK, 8'h07);
    u_ctl.wr(OFF_STATUS, 8'h0F);
    for (k = 0; k < 4; k++) begin
      temp <= k == 0 ? 8'hDF : k == 3 ? 8'hDE : 8'h00;
      sup <= k == 1 ? 8'h5A : k == 2 ? 8'h8A : 8'h5B;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(16'(irq), 16'(k < 3));
      @(posedge clk);
      u_ctl.rd(OFF_STATUS, d);
      chk(16'(d), k < 3 ? 16'h1 << k : 16'h0);
      {temp, sup} <= {8'h00, 8'h70};
      @(posedge clk);
      u_ctl.wr(OFF_STATUS, 8'h0F);
    end
    // masked fault stays silent, then blinks the indicator
    u_ctl.wr(OFF_MASK, 8'h00);
    temp <= 8'hF0;
    u_ctl.wr(OFF_FLASH, 8'h04);
    @(negedge clk);
    chk(16'(irq), 16'h0);
    for (n = 0, k = 0; k < 64; k++) begin
      @(negedge clk);
      n += led;
    end
    chk(16'(n), 16'd32);
    @(posedge clk);
    u_ctl.wr(OFF_RAMP_LIM, 8'h03);
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    for (n = 0; ramp === 1'b1 || n == 0; n++) begin
      @(negedge clk);
      if (n > 200) begin
        n_errors++;
        final_report();
      end
    end
    chk(16'(n >= 2 * TC && n <= 3 * TC + 2), 16'h1);
    final_report();
  end
endmodule : svp_param_bank_tb_top
bind svp_param_bank svp_chk u_chk (.CLOCK_I, .RST_I, .CE_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
  .IRQ_O, .TEMP_RAW_I, .SUPPLY_RAW_I, .DEST_ADDR_I, .ADDR_HIT_O, .GOAL_POS_I, .GOAL_STB_I, .CMD_POS_O,
  .CUR_POS_I, .DRIVE_O, .REACHED_O, .RAMP_ACTIVE_O);
`default_nettype wire

// >>> src/svp_drive_if.sv
// interface: parameters and error into the drive shaper, shaped drive back
`timescale 1ns/100ps
`default_nettype none
interface svp_drive_if;
  import svp_pkg::*;
  logic        [7:0]         settle_band;
  logic        [7:0]         drive_floor;
  logic        [15:0]        drive_ceiling;
  logic signed [POS_W:0]     pos_error;
  logic signed [DRIVE_W-1:0] raw_drive;
  logic signed [DRIVE_W-1:0] drive;
  logic                      reached;

  modport shaper (input settle_band, drive_floor, drive_ceiling, pos_error, raw_drive,
                  output drive, reached);
  modport bank   (output settle_band, drive_floor, drive_ceiling, pos_error, raw_drive,
                  input drive, reached);
endinterface : svp_drive_if
`default_nettype wire

// >>> src/svp_drive_shaper.sv
// module: settle band, drive floor and drive ceiling applied to the loop output
`timescale 1ns/100ps
`default_nettype none
module svp_drive_shaper (
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire logic     ce_i,
  svp_drive_if.shaper   dif
);
  import svp_pkg::*;

  svp_shape_t s_q;
  svp_shape_t s_d;

  // magnitudes of error and raw drive; extra bit on the raw drive magnitude avoids overflow on the most negative value
  logic [POS_W:0]   abs_err;
  logic [DRIVE_W:0] raw_mag;
  logic [DRIVE_W:0] mag;
  logic             in_band;

  // band test first, then floor, ceiling last so it always wins
  always_comb begin
    s_d     = s_q;
    abs_err = dif.pos_error[POS_W] ? (POS_W+1)'(-dif.pos_error) : (POS_W+1)'(dif.pos_error);
    raw_mag = dif.raw_drive[DRIVE_W-1] ? -{dif.raw_drive[DRIVE_W-1], dif.raw_drive}
                                       : {1'b0, dif.raw_drive};
    in_band = (abs_err == '0) || (abs_err < {3'h0, dif.settle_band});
    mag     = raw_mag;
    if (mag != '0 && mag < {9'h000, dif.drive_floor}) begin
      mag = {9'h000, dif.drive_floor};
    end
    if (mag > {1'b0, dif.drive_ceiling}) begin
      mag = {1'b0, dif.drive_ceiling};
    end
    if (in_band) begin
      s_d.drive = '0;
    end else if (dif.raw_drive[DRIVE_W-1]) begin
      s_d.drive = DRIVE_W'(-mag);
    end else begin
      s_d.drive = DRIVE_W'(mag);
    end
    s_d.reached = in_band;
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign dif.drive   = s_q.drive;
  assign dif.reached = s_q.reached;

endmodule : svp_drive_shaper
`default_nettype wire

// >>> src/svp_param_bank.sv
// module: volatile servo parameter store with fault checks, ramp, indicator and drive shaping
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module svp_param_bank #(
  parameter int unsigned TICK_CYC = svp_pkg::TICK_CYCLES
) (
  input  wire logic                                 CLOCK_I,
  input  wire logic                                 RST_I,
  input  wire logic                                 CE_I,
  input  wire logic        [7:0]                    ADDR_I,
  input  wire logic        [7:0]                    WDATA_I,
  input  wire logic                                 WR_I,
  input  wire logic                                 RD_I,
  output logic             [7:0]                    RDATA_O,
  output logic                                      IRQ_O,
  input  wire logic        [7:0]                    TEMP_RAW_I,
  input  wire logic        [7:0]                    SUPPLY_RAW_I,
  input  wire logic        [7:0]                    DEST_ADDR_I,
  output logic                                      ADDR_HIT_O,
  input  wire logic        [svp_pkg::POS_W-1:0]     GOAL_POS_I,
  input  wire logic                                 GOAL_STB_I,
  output logic             [svp_pkg::POS_W-1:0]     CMD_POS_O,
  input  wire logic        [svp_pkg::POS_W-1:0]     CUR_POS_I,
  input  wire logic signed [svp_pkg::DRIVE_W-1:0]   RAW_DRIVE_I,
  output logic signed      [svp_pkg::DRIVE_W-1:0]   DRIVE_O,
  output logic                                      REACHED_O,
  output logic                                      RAMP_ACTIVE_O,
  output logic                                      FAULT_LED_O
);
  import svp_pkg::*;

  svp_bank_t r_q;
  svp_bank_t r_d;

  svp_drive_if dif ();

  // decoded fields; word values pair low byte at the even offset with the next byte
  logic [7:0]      node_address;
  logic [7:0]      fault_indicator_select;
  logic [7:0]      temp_upper_limit;
  logic [7:0]      supply_lower_limit;
  logic [7:0]      supply_upper_limit;
  logic [7:0]      ramp_time_limit;
  logic [7:0]      indicator_flash_period;
  logic [15:0]     travel_lower_limit;
  logic [15:0]     travel_upper_limit;
  logic [ST_W-1:0] live;
  logic [ST_W-1:0] events;
  logic            tick;
  logic            wr_ok;

  assign node_address           = r_q.mem[OFF_NODE];
  assign fault_indicator_select = r_q.mem[OFF_IND_SEL];
  assign temp_upper_limit       = r_q.mem[OFF_TEMP_HI];
  assign supply_lower_limit     = r_q.mem[OFF_SUP_LO];
  assign supply_upper_limit     = r_q.mem[OFF_SUP_HI];
  assign ramp_time_limit        = r_q.mem[OFF_RAMP_LIM];
  assign indicator_flash_period = r_q.mem[OFF_FLASH];
  assign travel_lower_limit     = {r_q.mem[OFF_TRAV_LO + 8'h01], r_q.mem[OFF_TRAV_LO]};
  assign travel_upper_limit     = {r_q.mem[OFF_TRAV_HI + 8'h01], r_q.mem[OFF_TRAV_HI]};

  // shaper inputs come straight from the live store, so writes act on the next cycle
  assign dif.settle_band   = r_q.mem[OFF_SETTLE];
  assign dif.drive_floor   = r_q.mem[OFF_FLOOR];
  assign dif.drive_ceiling = {r_q.mem[OFF_CEIL + 8'h01], r_q.mem[OFF_CEIL]};
  assign dif.pos_error     = $signed({1'b0, r_q.cmd_pos}) - $signed({1'b0, CUR_POS_I});
  assign dif.raw_drive     = RAW_DRIVE_I;

  svp_drive_shaper u_shaper (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .ce_i  (CE_I),
    .dif   (dif)
  );

  // fault conditions, compared on raw codes as the limits are stored raw
  always_comb begin
    live             = '0;
    live[ST_TEMP]    = TEMP_RAW_I > temp_upper_limit;
    live[ST_SUP_LO]  = SUPPLY_RAW_I < supply_lower_limit;
    live[ST_SUP_HI]  = SUPPLY_RAW_I > supply_upper_limit;
    live[ST_REACHED] = dif.reached;
    events           = live;
  end

  assign tick = (r_q.tick_cnt == TICK_W'(TICK_CYC - 1));

  // a write is refused for reserved bytes and for values out of their legal range
  always_comb begin
    wr_ok = WR_I && (ADDR_I < 8'(NUM_BYTES));
    if (ADDR_I == OFF_RSVD4 || (ADDR_I >= OFF_RSVD34 && ADDR_I < OFF_FLASH)) begin
      wr_ok = 1'b0;
    end
    if (ADDR_I == OFF_NODE && WDATA_I >= BROADCAST_ADDR) begin
      wr_ok = 1'b0;
    end
    if (ADDR_I == OFF_RAMP_RATIO && WDATA_I > RAMP_RATIO_MAX) begin
      wr_ok = 1'b0;
    end
  end

  // next state of the whole bank
  always_comb begin
    r_d = r_q;

    // store writes; each byte is its own location
    if (wr_ok) begin
      r_d.mem[ADDR_I[5:0]] = WDATA_I;
    end
    if (WR_I && ADDR_I == OFF_MASK) begin
      r_d.mask = WDATA_I[ST_W-1:0];
    end

    // sticky events: write one to clear, a new event in the same cycle wins
    r_d.status = r_q.status;
    if (WR_I && ADDR_I == OFF_STATUS) begin
      r_d.status = r_q.status & ~WDATA_I[ST_W-1:0];
    end
    r_d.status = r_d.status | events;

    // read data valid the cycle after the strobe, zero for unmapped offsets
    r_d.rdata = 8'h00;
    if (RD_I) begin
      if (ADDR_I < 8'(NUM_BYTES)) begin
        r_d.rdata = r_q.mem[ADDR_I[5:0]];
      end else if (ADDR_I == OFF_STATUS) begin
        r_d.rdata = {{(8-ST_W){1'b0}}, r_q.status};
      end else if (ADDR_I == OFF_MASK) begin
        r_d.rdata = {{(8-ST_W){1'b0}}, r_q.mask};
      end else if (ADDR_I == OFF_LIVE) begin
        r_d.rdata = {{(8-ST_W){1'b0}}, live};
      end
    end

    // interrupt follows the status held after this cycle
    r_d.irq = |(r_d.status & r_d.mask);

    // free-running tick base
    r_d.tick_cnt = tick ? '0 : r_q.tick_cnt + 1'b1;

    // ramp window: limit byte loaded on a new goal, counted down one per tick
    if (GOAL_STB_I) begin
      r_d.ramp_cnt = ramp_time_limit;
    end else if (tick && r_q.ramp_cnt != 8'h00) begin
      r_d.ramp_cnt = r_q.ramp_cnt - 8'h01;
    end
    r_d.ramp_active = (r_d.ramp_cnt != 8'h00);

    // target confined to the travel window; lower limit wins if the window is inverted
    if (GOAL_STB_I) begin
      if ({6'h00, GOAL_POS_I} > travel_upper_limit) begin
        r_d.cmd_pos = POS_W'(travel_upper_limit);
      end else begin
        r_d.cmd_pos = GOAL_POS_I;
      end
      if ({6'h00, r_d.cmd_pos} < travel_lower_limit) begin
        r_d.cmd_pos = POS_W'(travel_lower_limit);
      end
    end

    // indicator period is the flash byte in ticks; lit for the second half of it
    if (tick) begin
      if (indicator_flash_period == 8'h00 || r_q.blink_cnt >= indicator_flash_period - 8'h01) begin
        r_d.blink_cnt = 8'h00;
      end else begin
        r_d.blink_cnt = r_q.blink_cnt + 8'h01;
      end
    end
    r_d.led = (|(r_q.status[ST_SUP_HI:ST_TEMP] & fault_indicator_select[ST_SUP_HI:ST_TEMP]))
              && (r_q.blink_cnt >= (indicator_flash_period >> 1));

    // broadcast code always matches, own address matches too
    r_d.addr_hit = (DEST_ADDR_I == BROADCAST_ADDR) || (DEST_ADDR_I == node_address);
  end

  // reboot reloads the default image; all state frozen while the enable is low
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      r_q.mem         <= DEFAULT_IMAGE;
      r_q.status      <= STATUS_RESET;
      r_q.mask        <= MASK_RESET;
      r_q.rdata       <= 8'h00;
      r_q.tick_cnt    <= '0;
      r_q.ramp_cnt    <= 8'h00;
      r_q.ramp_active <= 1'b0;
      r_q.blink_cnt   <= 8'h00;
      r_q.led         <= 1'b0;
      r_q.irq         <= 1'b0;
      r_q.addr_hit    <= 1'b0;
      r_q.cmd_pos     <= POS_RESET;
    end else if (CE_I) begin
      r_q <= r_d;
    end
  end

  // outputs straight from flip-flops
  assign RDATA_O       = r_q.rdata;
  assign IRQ_O         = r_q.irq;
  assign ADDR_HIT_O    = r_q.addr_hit;
  assign CMD_POS_O     = r_q.cmd_pos;
  assign DRIVE_O       = dif.drive;
  assign REACHED_O     = dif.reached;
  assign RAMP_ACTIVE_O = r_q.ramp_active;
  assign FAULT_LED_O   = r_q.led;

endmodule : svp_param_bank
`default_nettype wire

// >>> src/svp_pkg.sv
// package: offsets, reset image, timing and state types of the servo parameter bank
package svp_pkg;

  // byte store geometry and data widths
  localparam int unsigned NUM_BYTES = 39;
  localparam int unsigned POS_W     = 10;
  localparam int unsigned DRIVE_W   = 16;
  localparam int unsigned ST_W      = 4;
  localparam int unsigned TICK_W    = 20;

  // byte offsets of the volatile store
  localparam logic [7:0] OFF_NODE       = 8'h00;
  localparam logic [7:0] OFF_REPLY      = 8'h01;
  localparam logic [7:0] OFF_IND_SEL    = 8'h02;
  localparam logic [7:0] OFF_REL_SEL    = 8'h03;
  localparam logic [7:0] OFF_RSVD4      = 8'h04;
  localparam logic [7:0] OFF_TEMP_HI    = 8'h05;
  localparam logic [7:0] OFF_SUP_LO     = 8'h06;
  localparam logic [7:0] OFF_SUP_HI     = 8'h07;
  localparam logic [7:0] OFF_RAMP_RATIO = 8'h08;
  localparam logic [7:0] OFF_RAMP_LIM   = 8'h09;
  localparam logic [7:0] OFF_SETTLE     = 8'h0A;
  localparam logic [7:0] OFF_LIM_BASE   = 8'h0B;
  localparam logic [7:0] OFF_LIM_GRAD   = 8'h0C;
  localparam logic [7:0] OFF_BIAS       = 8'h0E;
  localparam logic [7:0] OFF_FLOOR      = 8'h0F;
  localparam logic [7:0] OFF_CEIL       = 8'h10;
  localparam logic [7:0] OFF_OVLD       = 8'h12;
  localparam logic [7:0] OFF_TRAV_LO    = 8'h14;
  localparam logic [7:0] OFF_TRAV_HI    = 8'h16;
  localparam logic [7:0] OFF_KP         = 8'h18;
  localparam logic [7:0] OFF_KD         = 8'h1A;
  localparam logic [7:0] OFF_KI         = 8'h1C;
  localparam logic [7:0] OFF_FF1        = 8'h1E;
  localparam logic [7:0] OFF_FF2        = 8'h20;
  localparam logic [7:0] OFF_RSVD34     = 8'h22;
  localparam logic [7:0] OFF_RSVD36     = 8'h24;
  localparam logic [7:0] OFF_FLASH      = 8'h26;

  // event status, mask and live fault view
  localparam logic [7:0] OFF_STATUS     = 8'h40;
  localparam logic [7:0] OFF_MASK       = 8'h41;
  localparam logic [7:0] OFF_LIVE       = 8'h42;

  // status bit positions
  localparam int unsigned ST_TEMP    = 0;
  localparam int unsigned ST_SUP_LO  = 1;
  localparam int unsigned ST_SUP_HI  = 2;
  localparam int unsigned ST_REACHED = 3;

  // value limits
  localparam logic [7:0] BROADCAST_ADDR = 8'hFE;
  localparam logic [7:0] RAMP_RATIO_MAX = 8'h32;

  // reset values
  localparam logic [ST_W-1:0]  STATUS_RESET = 4'h0;
  localparam logic [ST_W-1:0]  MASK_RESET   = 4'h0;
  localparam logic [POS_W-1:0] POS_RESET    = 10'h000;

  // non-volatile default image, byte 38 first down to byte 0
  localparam logic [NUM_BYTES-1:0][7:0] DEFAULT_IMAGE = {
    8'h2D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h1F, 8'h40, 8'h01, 8'hB8, 8'h03,
    8'hEA, 8'h00, 8'h15, 8'h03, 8'hFE, 8'h03, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2D, 8'h19,
    8'h89, 8'h5B, 8'hDE, 8'h00, 8'h35, 8'h7F, 8'h01, 8'hFD};

  // timing: one tick of 11.2 ms at a 20 ns clock
  localparam int unsigned TICK_PERIOD_US = 11200;
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;

  // state of the parameter bank
  typedef struct packed {
    logic [NUM_BYTES-1:0][7:0] mem;
    logic [ST_W-1:0]           status;
    logic [ST_W-1:0]           mask;
    logic [7:0]                rdata;
    logic [TICK_W-1:0]         tick_cnt;
    logic [7:0]                ramp_cnt;
    logic                      ramp_active;
    logic [7:0]                blink_cnt;
    logic                      led;
    logic                      irq;
    logic                      addr_hit;
    logic [POS_W-1:0]          cmd_pos;
  } svp_bank_t;

  // state of the drive shaper
  typedef struct packed {
    logic signed [DRIVE_W-1:0] drive;
    logic                      reached;
  } svp_shape_t;

endpackage : svp_pkg
